// file: pkg/scm_params.svh
// Constants for the serial configuration memory port
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
`define SCM_WORD_W 8
`define SCM_BITCNT_W 3
`define SCM_BITCNT_LAST 3'h7
`define SCM_BITCNT_ZERO 3'h0
`define SCM_WORD_ZERO 8'h00
`define SCM_BUF_DEPTH 2
`endif

// file: pkg/scm_pkg.sv
// Types for the serial configuration memory port
`default_nettype none
package scm_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic first;
    } scm_word_t;
    typedef enum logic [1:0] {
        SCM_ST_WAKE = 2'b00,
        SCM_ST_IDLE = 2'b01,
        SCM_ST_ACTIVE = 2'b10
    } scm_state_t;
endpackage
`default_nettype wire

// file: rtl/scm_buf.sv
// Two-entry valid/ready buffer for words
`timescale 1ns/1ps
`default_nettype none
module scm_buf #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire scm_pkg::scm_word_t in_word,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output scm_pkg::scm_word_t out_word
);
    import scm_pkg::*;
    scm_word_t mem_r [DEPTH];
    logic [$clog2(DEPTH):0] cnt_r;
    logic [$clog2(DEPTH)-1:0] wp_r;
    logic [$clog2(DEPTH)-1:0] rp_r;
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready = (cnt_r != ($clog2(DEPTH)+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_word = mem_r[rp_r];

    // Storage written by index
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_word;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// file: rtl/scm_port.sv
// Serial port of a configuration memory, device side
// Overview of operation
// - Serial output changes only on serial clock falling edges while selected.
// - Serial input is captured on serial clock rising edges and forms the incoming words.
// - With select high the output is released to high impedance.
// - With select low the port shifts in and drives out data.
// - After reset nothing happens until a falling edge on select is seen.
`timescale 1ns/1ps
`default_nettype none
`include "scm_params.svh"
module scm_port (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Serial pins
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    // Received words
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [`SCM_WORD_W-1:0] rx_data,
    output logic rx_first,
    // Words to send and awake flag
    input wire logic [`SCM_WORD_W-1:0] tx_data,
    output logic tx_take,
    output logic awake
);
    import scm_pkg::*;
    logic [1:0] clk_s_r;
    logic [1:0] sel_s_r;
    logic in_s1_r;
    logic in_s2_r;
    logic clk_d_r;
    logic sel_d_r;
    logic rise;
    logic fall;
    logic sel_fall;
    logic selected;
    scm_state_t st_r;
    logic [`SCM_BITCNT_W-1:0] bit_r;
    logic [`SCM_WORD_W-1:0] sh_r;
    logic [`SCM_WORD_W-1:0] tx_sh_r;
    logic first_r;
    logic push;
    scm_word_t push_word;
    scm_word_t pop_word;
    logic pop_valid;
    logic rx_valid_r;
    logic [`SCM_WORD_W-1:0] rx_data_r;
    logic rx_first_r;
    logic serial_out_r;
    logic serial_out_en_r;
    logic tx_take_r;
    logic out_take;

    // Two-stage synchronisers for pins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clk_s_r <= 2'h0;
            sel_s_r <= 2'h3;
            in_s1_r <= 1'b0;
            in_s2_r <= 1'b0;
        end else begin
            clk_s_r <= {clk_s_r[0], serial_clk};
            sel_s_r <= {sel_s_r[0], select_n};
            in_s1_r <= serial_in;
            in_s2_r <= in_s1_r;
        end
    end

    // Edge history from second stage
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clk_d_r <= 1'b0;
            sel_d_r <= 1'b1;
        end else begin
            clk_d_r <= clk_s_r[1];
            sel_d_r <= sel_s_r[1];
        end
    end

    // Edge detection
    assign rise = clk_s_r[1] && !clk_d_r;
    assign fall = !clk_s_r[1] && clk_d_r;
    assign sel_fall = !sel_s_r[1] && sel_d_r;
    assign selected = (st_r == SCM_ST_ACTIVE) && !sel_s_r[1];

    // Wake and framing state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= SCM_ST_WAKE;
        end else begin
            case (st_r)
                SCM_ST_WAKE: begin
                    if (sel_fall) begin
                        st_r <= SCM_ST_ACTIVE;
                    end
                end
                SCM_ST_IDLE: begin
                    if (sel_fall) begin
                        st_r <= SCM_ST_ACTIVE;
                    end
                end
                SCM_ST_ACTIVE: begin
                    if (sel_s_r[1]) begin
                        st_r <= SCM_ST_IDLE;
                    end
                end
                default: begin
                    st_r <= SCM_ST_WAKE;
                end
            endcase
        end
    end

    // Input shifter on rising serial edges
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bit_r <= `SCM_BITCNT_ZERO;
            sh_r <= `SCM_WORD_ZERO;
            first_r <= 1'b1;
        end else if (!selected) begin
            bit_r <= `SCM_BITCNT_ZERO;
            first_r <= 1'b1;
        end else if (rise) begin
            sh_r <= {sh_r[`SCM_WORD_W-2:0], in_s2_r};
            bit_r <= bit_r + 1'b1;
            if (bit_r == `SCM_BITCNT_LAST) begin
                first_r <= 1'b0;
            end
        end
    end

    assign push = selected && rise && (bit_r == `SCM_BITCNT_LAST);
    assign push_word = '{data: {sh_r[`SCM_WORD_W-2:0], in_s2_r}, first: first_r};

    scm_buf #(
        .DEPTH(`SCM_BUF_DEPTH)
    ) u_buf (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(push),
        .in_ready(),
        .in_word(push_word),
        .out_valid(pop_valid),
        .out_ready(out_take),
        .out_word(pop_word)
    );

    // Output register stage for received words
    assign out_take = pop_valid && (!rx_valid_r || rx_ready);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_valid_r <= 1'b0;
            rx_data_r <= `SCM_WORD_ZERO;
            rx_first_r <= 1'b0;
        end else if (out_take) begin
            rx_valid_r <= 1'b1;
            rx_data_r <= pop_word.data;
            rx_first_r <= pop_word.first;
        end else if (rx_ready) begin
            rx_valid_r <= 1'b0;
        end
    end

    // Output shifter: loads a word at frame start and each word end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_r <= `SCM_WORD_ZERO;
            serial_out_r <= 1'b0;
            serial_out_en_r <= 1'b0;
            tx_take_r <= 1'b0;
        end else begin
            tx_take_r <= 1'b0;
            serial_out_en_r <= selected;
            if (!selected) begin
                tx_sh_r <= tx_data;
            end else if (fall) begin
                serial_out_r <= tx_sh_r[`SCM_WORD_W-1];
                if (bit_r == `SCM_BITCNT_ZERO) begin
                    tx_sh_r <= {tx_data[`SCM_WORD_W-2:0], 1'b0};
                    serial_out_r <= tx_data[`SCM_WORD_W-1];
                    tx_take_r <= 1'b1;
                end else begin
                    tx_sh_r <= {tx_sh_r[`SCM_WORD_W-2:0], 1'b0};
                end
            end
        end
    end

    assign serial_out = serial_out_r;
    assign serial_out_en = serial_out_en_r;
    assign rx_valid = rx_valid_r;
    assign rx_data = rx_data_r;
    assign rx_first = rx_first_r;
    assign tx_take = tx_take_r;

    // Awake flag register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            awake <= 1'b0;
        end else begin
            awake <= (st_r != SCM_ST_WAKE);
        end
    end

    // Output only changes after a falling serial edge
    a_out_on_fall: assert property (@(posedge clock) disable iff (!rst_b)
        (serial_out_en && $changed(serial_out) && $past(serial_out_en)) |-> $past(fall))
        else $error("serial output changed without a falling edge");

    // Pushed byte matches the shifter and the bit count wraps
    a_rx_capture: assert property (@(posedge clock) disable iff (!rst_b)
        push |=> (sh_r == $past(push_word.data)) && (bit_r == `SCM_BITCNT_ZERO))
        else $error("captured byte or bit count mismatch");

    // Deselect releases output in one cycle
    a_release_out: assert property (@(posedge clock) disable iff (!rst_b)
        sel_s_r[1] |=> !serial_out_en)
        else $error("output driven while deselected");

    // Selection enables drive
    a_drive_sel: assert property (@(posedge clock) disable iff (!rst_b)
        selected |=> serial_out_en)
        else $error("output not driven while selected");

    // No activity before wake edge
    sequence s_asleep;
        st_r == SCM_ST_WAKE;
    endsequence
    a_wake_first: assert property (@(posedge clock) disable iff (!rst_b)
        s_asleep |-> !push && !serial_out_en)
        else $error("activity before first select fall");

    // Wake only through select fall
    a_wake_edge: assert property (@(posedge clock) disable iff (!rst_b)
        (s_asleep ##1 st_r != SCM_ST_WAKE) |-> $past(sel_fall))
        else $error("woke without select fall");

    // Frame ends on select rise
    a_frame_end: assert property (@(posedge clock) disable iff (!rst_b)
        (st_r == SCM_ST_ACTIVE && sel_s_r[1]) |=> st_r == SCM_ST_IDLE)
        else $error("frame did not end");

    // Bit counter advances on rising edges only
    a_bit_rise: assert property (@(posedge clock) disable iff (!rst_b)
        (selected && $past(selected) && $changed(bit_r)) |-> $past(rise))
        else $error("bit count moved without rising edge");
endmodule
`default_nettype wire

// file: test/scm_host_model.sv
// Behavioural host that clocks frames into and out of the port
`timescale 1ns/1ps
`default_nettype none
module scm_host_model (
    // System clock for pacing
    input wire logic clock,
    // Serial pins
    output logic serial_clk,
    output logic select_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en
);
    logic line;
    logic prev_out;
    logic prev_en;
    int late_changes;
    int dark_bits;
    // Released line shows no stale value
    assign line = serial_out_en ? serial_out : ~prev_out;
    // Idle: select high, serial clock parked high
    initial begin
        serial_clk = 1'b1;
        select_n = 1'b1;
        serial_in = 1'b0;
        late_changes = 0;
        dark_bits = 0;
    end
    // Output may move only in the low half of the serial clock
    always @(posedge clock) begin
        prev_out <= serial_out;
        prev_en <= serial_out_en;
        if (serial_out_en && prev_en && !select_n && serial_clk && serial_out !== prev_out) begin
            late_changes <= late_changes + 1;
        end
    end
    // One framed transfer, MSB first, clock idle high
    task automatic frame(input int nbits, input logic [15:0] mosi, output logic [15:0] miso);
        miso = 16'h0000;
        select_n <= 1'b0;
        repeat (8) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            serial_clk <= 1'b0;
            serial_in <= mosi[15 - i];
            repeat (8) @(posedge clock);
            serial_clk <= 1'b1;
            miso[15 - i] = line;
            if (serial_out_en !== 1'b1) dark_bits++;
            repeat (8) @(posedge clock);
        end
        select_n <= 1'b1;
        serial_in <= ~serial_in;
        repeat (20) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// file: test/scm_port_tb.sv
// Self-checking bench for the serial configuration memory port
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
end
module scm_port_tb;
    logic clock, rst_b, serial_clk, select_n, serial_in, serial_out, serial_out_en;
    logic rx_valid, rx_ready, rx_first, tx_take, awake;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic [15:0] miso;
    int fails;
    int samples_checked;
    // System clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    scm_port u_scm_port (.clock(clock), .rst_b(rst_b), .serial_clk(serial_clk), .select_n(select_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_first(rx_first),
        .tx_data(tx_data), .tx_take(tx_take), .awake(awake));
    scm_host_model u_scm_host_model (.clock(clock), .serial_clk(serial_clk), .select_n(select_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en));
    // Next outgoing byte is the inverse of the last one taken
    always @(posedge clock) begin
        if (tx_take === 1'b1) tx_data <= ~tx_data;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Take one received byte and compare it
    task automatic pop(input logic [7:0] exp_d, input logic exp_f);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 200) begin
            @(posedge clock);
            n++;
        end
        if (rx_valid !== 1'b1) begin
            fails++;
            final_report();
        end
        `CHK("rx_data", exp_d, rx_data)
        `CHK("rx_first", exp_f, rx_first)
        rx_ready <= 1'b1;
        @(posedge clock);
        rx_ready <= 1'b0;
        @(posedge clock);
    endtask
    // Idle after reset: asleep and released
    task automatic wake_check();
        repeat (20) @(posedge clock);
        `CHK("awake", 1'b0, awake)
        `CHK("serial_out_en", 1'b0, serial_out_en)
    endtask
    // Single byte each way
    task automatic one_byte();
        tx_data <= 8'ha5;
        @(posedge clock);
        u_scm_host_model.frame(8, 16'h3c00, miso);
        `CHK("miso", 8'ha5, miso[15:8])
        `CHK("awake", 1'b1, awake)
        `CHK("serial_out_en", 1'b0, serial_out_en)
        `CHK("dark_bits", 0, u_scm_host_model.dark_bits)
        pop(8'h3c, 1'b1);
    endtask
    // Two frames while stalled, one ending in a partial byte
    task automatic stall_pair();
        tx_data <= 8'h81;
        @(posedge clock);
        u_scm_host_model.frame(16, 16'h5ac3, miso);
        `CHK("miso pair", 16'h817e, miso)
        u_scm_host_model.frame(12, 16'h9670, miso);
        `CHK("miso part", 12'h817, miso[15:4])
        pop(8'h5a, 1'b1);
        pop(8'hc3, 1'b0);
        pop(8'h96, 1'b1);
        repeat (20) @(posedge clock);
        `CHK("rx_valid", 1'b0, rx_valid)
        `CHK("late_changes", 0, u_scm_host_model.late_changes)
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        rx_ready = 1'b0;
        tx_data = 8'h00;
        fails = 0;
        samples_checked = 0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        wake_check();
        one_byte();
        stall_pair();
        final_report();
    end
endmodule
`default_nettype wire
